/* File: rtl/gpt_pkg.sv */
// Shared constants and the top-level state type of the pulse totalizer block
package gpt_pkg;
   localparam int CNT_W = 26;
   localparam logic [25:0] CNT_MAX = 26'h3FFFFFF;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int PORT_W = 8;
   localparam int DAC_W = 16;
   // Fastest pulse rate and the clock, for the minimum pulse period
   localparam int CLK_KHZ = 200000;
   localparam int PULSE_MAX_KHZ = 100;
   localparam int PULSE_PER_CYC = CLK_KHZ / PULSE_MAX_KHZ;
   // Register offsets (byte addresses)
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CNT = 8'h04;
   localparam logic [7:0] A_CNT_CLR = 8'h08;
   localparam logic [7:0] A_PORT0 = 8'h0C;
   localparam logic [7:0] A_PORT1 = 8'h10;
   localparam logic [7:0] A_WORD = 8'h14;
   localparam logic [7:0] A_DAC0 = 8'h18;
   localparam logic [7:0] A_DAC1 = 8'h1C;
   localparam logic [7:0] A_STAT = 8'h20;
   // Control field positions
   localparam int C_FALL = 0;
   localparam int C_ZC = 1;
   localparam int C_SCAN0 = 2;
   localparam int C_SCAN1 = 3;
   localparam int C_RUN = 4;
   // Status field positions, write one to clear
   localparam int S_REFUSED = 0;
   localparam int S_WRAP = 1;
   // Reset values
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [15:0] OE_RST = 16'h0000;
   localparam logic [15:0] DAC_RST = 16'h8000;

   typedef struct packed {
      logic [25:0] cnt;
      logic [4:0]  ctrl;
      logic [15:0] oe;
      logic [15:0] drv;
      logic [15:0] dac0;
      logic [15:0] dac1;
      logic [31:0] rdata;
      logic [7:0]  local_data;
      logic        refused;
      logic        wrapped;
   } gpt_top_st_t;
endpackage

/* File: rtl/gpt_cond_if.sv */
// Conditioned pin signals passed from the input stage to the core
`timescale 1ns/1ps
interface gpt_cond_if;
   logic        edge_fall;
   logic        thr_zc;
   logic        qual_edge;
   logic [15:0] port_sync;
   modport core (output edge_fall, output thr_zc, input qual_edge, input port_sync);
   modport cond (input edge_fall, input thr_zc, output qual_edge, output port_sync);
endinterface

/* File: rtl/gpt_input_cond.sv */
// Pin synchronisers, edge selection and gating of the totalizer input
`timescale 1ns/1ps
module gpt_input_cond (
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic        pulse_lvl_in,
   input  wire logic        pulse_zc_in,
   input  wire logic        gate_hi_in,
   input  wire logic        gate_lo_n_in,
   input  wire logic [15:0] port_pin_in,
   gpt_cond_if.cond         cif
);
   typedef struct packed {
      logic [1:0]  lvl;
      logic [1:0]  zc;
      logic        pul;
      logic [1:0]  ghi;
      logic [1:0]  glo_n;
      logic [15:0] pt1;
      logic [15:0] pt2;
      logic        qual;
   } gpt_cond_st_t;

   gpt_cond_st_t s_q;
   gpt_cond_st_t s_d;
   logic         sel_pin;
   logic         edge_seen;
   logic         gates_open;

   // Threshold choice; changing it may cause one stray edge
   assign sel_pin = cif.thr_zc ? s_q.zc[1] : s_q.lvl[1];

   always_comb begin
      s_d = s_q;
      s_d.lvl = {s_q.lvl[0], pulse_lvl_in};
      s_d.zc = {s_q.zc[0], pulse_zc_in};
      s_d.pul = sel_pin;
      s_d.ghi = {s_q.ghi[0], gate_hi_in};
      s_d.glo_n = {s_q.glo_n[0], gate_lo_n_in};
      s_d.pt1 = port_pin_in;
      s_d.pt2 = s_q.pt1;
      // Edge judged behind both sync stages, never on the first
      if (cif.edge_fall) begin
         edge_seen = !sel_pin && s_q.pul;
      end else begin
         edge_seen = sel_pin && !s_q.pul;
      end
      // Both gates must enable at once
      gates_open = s_q.ghi[1] && !s_q.glo_n[1];
      s_d.qual = edge_seen && gates_open;
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cif.qual_edge = s_q.qual;
   assign cif.port_sync = s_q.pt2;

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   sequence rise_s;
      sel_pin && !s_q.pul && !cif.edge_fall;
   endsequence
   sequence fall_s;
      !sel_pin && s_q.pul && cif.edge_fall;
   endsequence

   chk_edge_rise_counted: assert property (
      rise_s ##0 (s_q.ghi[1] && !s_q.glo_n[1]) |=> cif.qual_edge)
      else $error("rising edge with open gates not passed");
   chk_edge_fall_counted: assert property (
      fall_s ##0 (s_q.ghi[1] && !s_q.glo_n[1]) |=> cif.qual_edge)
      else $error("falling edge with open gates not passed");
   chk_gate_both_open: assert property (
      cif.qual_edge |-> $past(s_q.ghi[1]) && !$past(s_q.glo_n[1]))
      else $error("edge passed while a gate was closed");
endmodule

/* File: rtl/gpt_totalizer_top.sv */
// Gated pulse totalizer, digital port pair and analog output codes
// Overview of operation
// - Counter is 26 bits, zero to maximum.
// - Count qualified pulses up to 100 kHz.
// - Control bit picks rising or falling edge.
// - High-true gate enables counting while high.
// - Low-true gate enables counting while low.
// - Count only when both gates enable.
// - Threshold select, logic level by default.
// - Two eight-bit ports, input and output.
// - Local read returns one port only.
// - Word read only when no port scanned.
// - Ports and count readable during scans.
// - Each analog channel takes 16-bit code.
// - Count read plain or read-then-clear.
`timescale 1ns/1ps
module gpt_totalizer_top (
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   input  wire logic        local_rd_in,
   input  wire logic        local_sel_in,
   output logic [7:0]       local_data_out,
   input  wire logic        pulse_lvl_in,
   input  wire logic        pulse_zc_in,
   input  wire logic        gate_hi_in,
   input  wire logic        gate_lo_n_in,
   input  wire logic [15:0] port_pin_in,
   output logic [15:0]      port_drv_out,
   output logic [15:0]      port_oe_out,
   output logic [15:0]      dac0_code_out,
   output logic [15:0]      dac1_code_out,
   output logic [25:0]      count_out
);
   gpt_pkg::gpt_top_st_t s_q;
   gpt_pkg::gpt_top_st_t s_d;
   gpt_cond_if           cif ();
   logic                 scan_busy;
   logic                 edge_ev;
   logic [15:0]          pins;

   gpt_input_cond u_cond (
      .mclk_in      (mclk_in),
      .nrst_in      (nrst_in),
      .pulse_lvl_in (pulse_lvl_in),
      .pulse_zc_in  (pulse_zc_in),
      .gate_hi_in   (gate_hi_in),
      .gate_lo_n_in (gate_lo_n_in),
      .port_pin_in  (port_pin_in),
      .cif          (cif.cond)
   );

   assign cif.edge_fall = s_q.ctrl[gpt_pkg::C_FALL];
   assign cif.thr_zc = s_q.ctrl[gpt_pkg::C_ZC];
   assign edge_ev = cif.qual_edge;
   assign pins = cif.port_sync;
   assign scan_busy = s_q.ctrl[gpt_pkg::C_SCAN0] || s_q.ctrl[gpt_pkg::C_SCAN1];

   function automatic logic [25:0] next_count(input logic [25:0] c);
      // Past the top the count rolls back to zero
      if (c == gpt_pkg::CNT_MAX) begin
         next_count = 26'h0000000;
      end else begin
         next_count = c + 26'h0000001;
      end
   endfunction

   function automatic logic [31:0] zext8(input logic [7:0] v);
      zext8 = {24'h000000, v};
   endfunction

   function automatic logic [31:0] zext16(input logic [15:0] v);
      zext16 = {16'h0000, v};
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.rdata = 32'h00000000;

      // Counting; a pulse in the clearing cycle survives as one
      if (edge_ev) begin
         s_d.cnt = next_count(s_q.cnt);
         if (s_q.cnt == gpt_pkg::CNT_MAX) begin
            s_d.wrapped = 1'b1;
         end
      end

      // Register writes
      if (wr_in) begin
         if (addr_in == gpt_pkg::A_CTRL) begin
            s_d.ctrl = wdata_in[4:0];
         end else if (addr_in == gpt_pkg::A_CNT) begin
            // Preset lets software reach the rollover; a pulse here still counts
            s_d.cnt = edge_ev ? next_count(wdata_in[25:0]) : wdata_in[25:0];
         end else if (addr_in == gpt_pkg::A_PORT0) begin
            // Open drain: a zero bit pulls the pin low
            s_d.oe[7:0] = ~wdata_in[7:0];
         end else if (addr_in == gpt_pkg::A_PORT1) begin
            s_d.oe[15:8] = ~wdata_in[7:0];
         end else if (addr_in == gpt_pkg::A_WORD) begin
            s_d.oe = ~wdata_in[15:0];
         end else if (addr_in == gpt_pkg::A_DAC0) begin
            s_d.dac0 = wdata_in[15:0];
         end else if (addr_in == gpt_pkg::A_DAC1) begin
            s_d.dac1 = wdata_in[15:0];
         end else if (addr_in == gpt_pkg::A_STAT) begin
            // Clear loses to a same-cycle set
            if (wdata_in[gpt_pkg::S_WRAP] && !(edge_ev && s_q.cnt == gpt_pkg::CNT_MAX)) begin
               s_d.wrapped = 1'b0;
            end
            if (wdata_in[gpt_pkg::S_REFUSED]) begin
               s_d.refused = 1'b0;
            end
         end
      end

      // Register reads; data stand only in the next cycle
      if (rd_in) begin
         if (addr_in == gpt_pkg::A_CTRL) begin
            s_d.rdata = {27'h0000000, s_q.ctrl};
         end else if (addr_in == gpt_pkg::A_CNT) begin
            s_d.rdata = {6'h00, s_q.cnt};
         end else if (addr_in == gpt_pkg::A_CNT_CLR) begin
            s_d.rdata = {6'h00, s_q.cnt};
            s_d.cnt = edge_ev ? 26'h0000001 : 26'h0000000;
         end else if (addr_in == gpt_pkg::A_PORT0) begin
            s_d.rdata = zext8(pins[7:0]);
         end else if (addr_in == gpt_pkg::A_PORT1) begin
            s_d.rdata = zext8(pins[15:8]);
         end else if (addr_in == gpt_pkg::A_WORD) begin
            // Scanned ports make the word read answer zero
            if (scan_busy) begin
               s_d.refused = 1'b1;
            end else begin
               s_d.rdata = zext16(pins);
            end
         end else if (addr_in == gpt_pkg::A_DAC0) begin
            s_d.rdata = zext16(s_q.dac0);
         end else if (addr_in == gpt_pkg::A_DAC1) begin
            s_d.rdata = zext16(s_q.dac1);
         end else if (addr_in == gpt_pkg::A_STAT) begin
            s_d.rdata = {30'h00000000, s_q.wrapped, s_q.refused};
         end else begin
            s_d.rdata = 32'h00000000;
         end
      end

      // Local read gives a single byte, held until the next one
      if (local_rd_in) begin
         s_d.local_data = local_sel_in ? pins[15:8] : pins[7:0];
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q.cnt <= 26'h0000000;
         s_q.ctrl <= gpt_pkg::CTRL_RST;
         s_q.oe <= gpt_pkg::OE_RST;
         s_q.drv <= 16'h0000;
         s_q.dac0 <= gpt_pkg::DAC_RST;
         s_q.dac1 <= gpt_pkg::DAC_RST;
         s_q.rdata <= 32'h00000000;
         s_q.local_data <= 8'h00;
         s_q.refused <= 1'b0;
         s_q.wrapped <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_out = s_q.rdata;
   assign local_data_out = s_q.local_data;
   assign port_drv_out = s_q.drv;
   assign port_oe_out = s_q.oe;
   assign dac0_code_out = s_q.dac0;
   assign dac1_code_out = s_q.dac1;
   assign count_out = s_q.cnt;

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   sequence clr_read_s;
      rd_in && addr_in == gpt_pkg::A_CNT_CLR;
   endsequence

   sequence quiet_s;
      !(rd_in && addr_in == gpt_pkg::A_CNT_CLR) && !(wr_in && addr_in == gpt_pkg::A_CNT);
   endsequence

   sequence stat_wr_s;
      wr_in && addr_in == gpt_pkg::A_STAT;
   endsequence

   chk_count_step: assert property (
      edge_ev && s_q.cnt != gpt_pkg::CNT_MAX ##0 quiet_s
      |=> s_q.cnt == $past(s_q.cnt) + 26'h0000001)
      else $error("count did not advance by one");

   chk_count_wrap: assert property (
      edge_ev && s_q.cnt == gpt_pkg::CNT_MAX ##0 quiet_s
      |=> s_q.cnt == 26'h0000000 && s_q.wrapped)
      else $error("count did not wrap to zero");

   chk_count_hold: assert property (
      !edge_ev ##0 quiet_s |=> $stable(s_q.cnt))
      else $error("count moved with no qualified edge");

   chk_clear_read: assert property (
      clr_read_s |=> rdata_out == {6'h00, $past(s_q.cnt)}
      && s_q.cnt == {25'h0000000, $past(edge_ev)})
      else $error("read then clear gave wrong data or count");

   chk_plain_read: assert property (
      rd_in && addr_in == gpt_pkg::A_CNT && !edge_ev
      |=> rdata_out == {6'h00, s_q.cnt} ##1 rdata_out == 32'h00000000 || $past(rd_in))
      else $error("plain count read wrong or altered count");

   chk_word_refused: assert property (
      rd_in && addr_in == gpt_pkg::A_WORD && scan_busy
      |=> rdata_out == 32'h00000000 && s_q.refused)
      else $error("word read allowed while a port is scanned");

   chk_word_read: assert property (
      rd_in && addr_in == gpt_pkg::A_WORD && !scan_busy
      |=> rdata_out == {16'h0000, $past(pins)})
      else $error("word read data wrong");

   chk_local_byte: assert property (
      local_rd_in |=> local_data_out == ($past(local_sel_in) ?
      $past(pins[15:8]) : $past(pins[7:0])))
      else $error("local read byte wrong");

   chk_dac_load: assert property (
      wr_in && addr_in == gpt_pkg::A_DAC0
      |=> dac0_code_out == $past(wdata_in[15:0]))
      else $error("analog code not loaded");

   chk_port_drive: assert property (
      wr_in && addr_in == gpt_pkg::A_PORT1
      |=> port_oe_out[15:8] == ~$past(wdata_in[7:0]) && port_drv_out == 16'h0000)
      else $error("port output enables wrong");

   chk_count_preset: assert property (
      wr_in && addr_in == gpt_pkg::A_CNT && !edge_ev
      |=> s_q.cnt == $past(wdata_in[25:0]))
      else $error("count preset not loaded");

   chk_wrap_sticky: assert property (
      s_q.wrapped && !(wr_in && addr_in == gpt_pkg::A_STAT && wdata_in[gpt_pkg::S_WRAP])
      |=> s_q.wrapped)
      else $error("wrap flag lost without a clear");

   chk_wrap_clear: assert property (
      stat_wr_s ##0 (wdata_in[gpt_pkg::S_WRAP] && !edge_ev)
      |=> !s_q.wrapped)
      else $error("wrap flag not cleared");

   chk_refused_sticky: assert property (
      s_q.refused && !(wr_in && addr_in == gpt_pkg::A_STAT && wdata_in[gpt_pkg::S_REFUSED])
      |=> s_q.refused)
      else $error("refused flag lost without a clear");

   chk_stat_read: assert property (
      rd_in && addr_in == gpt_pkg::A_STAT
      |=> rdata_out == {30'h00000000, $past(s_q.wrapped), $past(s_q.refused)})
      else $error("status read wrong");

   chk_ctrl_load: assert property (
      wr_in && addr_in == gpt_pkg::A_CTRL
      |=> s_q.ctrl == $past(wdata_in[4:0]))
      else $error("control not loaded");

   chk_dac1_load: assert property (
      wr_in && addr_in == gpt_pkg::A_DAC1
      |=> dac1_code_out == $past(wdata_in[15:0]))
      else $error("second analog code not loaded");

   chk_port0_drive: assert property (
      wr_in && addr_in == gpt_pkg::A_PORT0
      |=> port_oe_out[7:0] == ~$past(wdata_in[7:0]))
      else $error("port zero output enables wrong");

   chk_port0_read: assert property (
      rd_in && addr_in == gpt_pkg::A_PORT0
      |=> rdata_out == {24'h000000, $past(pins[7:0])})
      else $error("port zero read wrong");

   chk_port1_read: assert property (
      rd_in && addr_in == gpt_pkg::A_PORT1
      |=> rdata_out == {24'h000000, $past(pins[15:8])})
      else $error("port one read wrong");

   chk_rdata_idle: assert property (
      !rd_in |=> rdata_out == 32'h00000000)
      else $error("read data stood without a read");

   chk_local_hold: assert property (
      !local_rd_in |=> $stable(local_data_out))
      else $error("local byte changed without a read");
endmodule

/* File: bench/gpt_pulse_src.sv */
// Pulse source standing at the far side of the totalizer input
`timescale 1ns/1ps
module gpt_pulse_src #(
   parameter int HALF = gpt_pkg::PULSE_PER_CYC / 2
) (
   input  wire logic       mclk_in,
   input  wire logic       start_in,
   input  wire logic [2:0] n_in,
   output logic            pulse_out,
   output logic            busy_out
);
   initial begin
      pulse_out = 1'b0;
      busy_out = 1'b0;
      forever begin
         @(posedge mclk_in);
         if (start_in) begin
            busy_out <= 1'b1;
            repeat (n_in) begin
               // Half period at the top rate, never faster
               pulse_out <= 1'b1;
               repeat (HALF) @(posedge mclk_in);
               pulse_out <= 1'b0;
               repeat (HALF) @(posedge mclk_in);
            end
            busy_out <= 1'b0;
         end
      end
   end
endmodule

/* File: bench/gated_pulse_totalizer_dio_tb.sv */
// Self-checking bench of the gated pulse totalizer block
`timescale 1ns/1ps
module gated_pulse_totalizer_dio_tb;
   logic        mclk_in = 0, nrst_in = 0, wr = 0, rd = 0, lrd = 0, lsel = 0;
   logic        gh = 1, gln = 0, zsel = 0, start = 0, pulse, busy;
   logic [7:0]  addr = 0, ldata;
   logic [31:0] wdata = 0, rdata;
   logic [2:0]  n = 0;
   logic [15:0] ext = 0, seed, pv, drv, oe, dac0, dac1, pins;
   logic [25:0] cnt, exp_cnt;
   int          errors = 0, comparisons = 0;

   // Open-drain lines with pull-ups: driven bits read low
   assign pins = ext & ~oe;

   initial forever #2.5 mclk_in = ~mclk_in;

   gpt_totalizer_top gpt_totalizer_top_i (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .local_rd_in(lrd),
      .local_sel_in(lsel), .local_data_out(ldata), .pulse_lvl_in(zsel ? 1'b0 : pulse),
      .pulse_zc_in(zsel ? pulse : 1'b0), .gate_hi_in(gh), .gate_lo_n_in(gln),
      .port_pin_in(pins), .port_drv_out(drv), .port_oe_out(oe),
      .dac0_code_out(dac0), .dac1_code_out(dac1), .count_out(cnt));

   gpt_pulse_src gpt_pulse_src_i (
      .mclk_in(mclk_in), .start_in(start), .n_in(n), .pulse_out(pulse), .busy_out(busy));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic gate_ok(input logic hi, input logic lo_n);
      return hi & ~lo_n;
   endfunction

   task automatic finish_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task automatic start_burst(input logic [2:0] k);
      @(posedge mclk_in);
      n <= k;
      start <= 1'b1;
      @(posedge mclk_in);
      start <= 1'b0;
   endtask

   task automatic wait_burst;
      @(posedge mclk_in);
      while (busy) @(posedge mclk_in);
      repeat (8) @(posedge mclk_in);
   endtask

   initial begin
      repeat (60000) @(posedge mclk_in);
      errors++;
      finish_test;
   end

   initial begin
      seed = 16'h9F01;
      exp_cnt = '0;
      repeat (20) @(posedge mclk_in);
      nrst_in <= 1'b1;
      @(posedge mclk_in);
      #1 chk(32'(cnt), 32'h0);
      chk(32'(dac0), 32'h8000);
      chk(32'(oe), 32'h0);
      rd_chk(gpt_pkg::A_CTRL, 32'h0);
      for (int i = 0; i < 2; i++) begin
         seed = lfsr(seed);
         wr_reg(i ? gpt_pkg::A_DAC1 : gpt_pkg::A_DAC0, {16'hFFFF, seed});
         rd_chk(i ? gpt_pkg::A_DAC1 : gpt_pkg::A_DAC0, 32'(seed));
         chk(32'(i ? dac1 : dac0), 32'(seed));
      end
      // Mid-pulse look tells the counting edge apart
      for (int f = 0; f < 2; f++) begin
         wr_reg(gpt_pkg::A_CTRL, 32'(f));
         start_burst(3'h1);
         repeat (12) @(posedge mclk_in);
         chk(32'(cnt), 32'(exp_cnt + 26'(f == 0)));
         wait_burst;
         exp_cnt = exp_cnt + 26'h1;
         chk(32'(cnt), 32'(exp_cnt));
      end
      for (int g = 0; g < 4; g++) begin
         gh <= g[0];
         gln <= g[1];
         repeat (6) @(posedge mclk_in);
         start_burst(3'h1);
         wait_burst;
         exp_cnt = exp_cnt + 26'(gate_ok(g[0], g[1]));
         chk(32'(cnt), 32'(exp_cnt));
      end
      gh <= 1'b1;
      gln <= 1'b0;
      zsel <= 1'b1;
      for (int t = 0; t < 2; t++) begin
         wr_reg(gpt_pkg::A_CTRL, 32'(t * 2));
         start_burst(3'h1);
         wait_burst;
         exp_cnt = exp_cnt + 26'(t);
         chk(32'(cnt), 32'(exp_cnt));
      end
      zsel <= 1'b0;
      wr_reg(gpt_pkg::A_CTRL, 32'h0);
      seed = lfsr(seed);
      start_burst(3'(seed[1:0]) + 3'h1);
      wait_burst;
      exp_cnt = exp_cnt + 26'(seed[1:0]) + 26'h1;
      rd_chk(gpt_pkg::A_CNT, 32'(exp_cnt));
      rd_chk(gpt_pkg::A_CNT_CLR, 32'(exp_cnt));
      rd_chk(gpt_pkg::A_CNT, 32'h0);
      // Preset just below the top, then roll over
      exp_cnt = gpt_pkg::CNT_MAX - 26'h1;
      wr_reg(gpt_pkg::A_CNT, 32'(exp_cnt));
      rd_chk(gpt_pkg::A_CNT, 32'(exp_cnt));
      start_burst(3'h3);
      wait_burst;
      exp_cnt = exp_cnt + 26'h3;
      rd_chk(gpt_pkg::A_CNT, 32'(exp_cnt));
      rd_chk(gpt_pkg::A_STAT, 32'h2);
      wr_reg(gpt_pkg::A_STAT, 32'h2);
      rd_chk(gpt_pkg::A_STAT, 32'h0);
      seed = lfsr(seed);
      @(posedge mclk_in);
      ext <= seed;
      repeat (4) @(posedge mclk_in);
      rd_chk(gpt_pkg::A_PORT0, 32'(seed[7:0]));
      rd_chk(gpt_pkg::A_PORT1, 32'(seed[15:8]));
      rd_chk(gpt_pkg::A_WORD, 32'(seed));
      seed = lfsr(seed);
      pv = ext & seed;
      wr_reg(gpt_pkg::A_WORD, 32'(seed));
      repeat (4) @(posedge mclk_in);
      #1 chk(32'(oe), {16'h0000, ~seed});
      chk(32'(drv), 32'h0);
      rd_chk(gpt_pkg::A_WORD, 32'(pv));
      for (int s = 0; s < 2; s++) begin
         @(posedge mclk_in);
         lrd <= 1'b1;
         lsel <= s[0];
         @(posedge mclk_in);
         lrd <= 1'b0;
         #1 chk(32'(ldata), 32'(s ? pv[15:8] : pv[7:0]));
      end
      for (int s = 1; s < 3; s++) begin
         wr_reg(gpt_pkg::A_CTRL, 32'((s << 2) | 16));
         rd_chk(gpt_pkg::A_WORD, 32'h0);
         rd_chk(gpt_pkg::A_STAT, 32'h1);
         wr_reg(gpt_pkg::A_STAT, 32'h1);
         rd_chk(gpt_pkg::A_PORT1, 32'(pv[15:8]));
         rd_chk(gpt_pkg::A_CNT, 32'(exp_cnt));
      end
      rd_chk(8'h24, 32'h0);
      finish_test;
   end
endmodule
